// file: wrf_top.sv
// wrf_top: register file with global set, four-frame local cache, memory spill/fill
// and a load scoreboard with forwarding.
// assumes: decoder offers one instruction per cycle and holds it while stalled;
// memory bus acknowledges one word per i_mem_ack pulse.
//
// Operation
// RL1: thirty-two registers visible: globals plus locals.
// RL2: sixteen globals kept across calls, never swapped.
// RL3: each call gets fresh sixteen-register local frame.
// RL4: cache holds four frames, three calls memoryless.
// RL5: full cache on call spills oldest frame.
// RL6: last global is frame pointer for spills.
// RL7: load issue sets destination pending flag.
// RL8: load data written clears pending flag.
// RL9: readers of pending registers stall, others issue.
// RL10: three loads outstanding; fourth waits.
// RL11: conditional instructions tracked, unrelated ones proceed.
// RL12: alu result written and bypassed simultaneously.
// RL13: return to uncached caller reloads frame first.
// RL14: load data forwarded to same-cycle stalled reader.
`default_nettype none

module wrf_top
	import wrf_pkg::*;
#(
	parameter int CACHE_FRAMES = WRF_CACHE_FRAMES,
	parameter int MAX_LOADS = WRF_MAX_LOADS,
	parameter int DEPTH_W = WRF_DEPTH_W
)
(
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire wrf_issue_t i_issue,
	input wire wrf_wr_t i_alu_wr,
	input wire wrf_wr_t i_ld_ret,
	input wire logic i_cond_done,
	input wire logic i_mem_ack,
	input wire logic [31:0] i_mem_rdata,
	output logic o_issue_stall,
	output wrf_opnd_t o_opnd,
	output wrf_wr_t o_bypass,
	output wrf_mem_req_t o_mem_req,
	output logic o_frame_busy,
	output logic [DEPTH_W-1:0] o_call_depth
);

	// storage
	logic [31:0] glb_reg [0:WRF_NUM_GLOBALS-1]; // global set
	logic [31:0] lcl_mem [0:CACHE_FRAMES*WRF_NUM_LOCALS-1]; // frame cache, slot-major

	// frame bookkeeping
	logic [1:0] cur_reg; // slot of running frame
	logic [1:0] cur_next;
	logic [2:0] cnt_reg; // frames currently cached
	logic [2:0] cnt_next;
	logic [DEPTH_W-1:0] depth_reg; // active procedures
	logic [DEPTH_W-1:0] depth_next;
	wrf_state_t state_reg;
	wrf_state_t state_next;
	logic [3:0] word_reg; // word within the frame being moved
	logic [3:0] word_next;
	logic [1:0] slot_reg; // slot being spilled or filled
	logic [1:0] slot_next;
	wrf_mem_req_t req_reg; // request held on the memory bus
	wrf_mem_req_t req_next;

	// other registered outputs
	wrf_opnd_t opnd_reg;
	wrf_opnd_t opnd_next;
	wrf_wr_t byp_reg;

	// scoreboard view
	logic [31:0] pending;
	logic cond_pending;
	logic sb_full;
	logic sb_any;

	// physical slot-major index of a local register
	function automatic logic [5:0] lcl_idx(input logic [1:0] slot, input logic [3:0] r);
		return {slot, r};
	endfunction

	// register read with write-through of same-cycle results; alu wins over load, as in the write path
	function automatic logic [31:0] fwd_read(input logic [4:0] r);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (i_alu_wr.valid && i_alu_wr.dst == r)
			v = i_alu_wr.data; // RL12
		else if (i_ld_ret.valid && i_ld_ret.dst == r)
			v = i_ld_ret.data; // RL14
		else if (r[4])
			v = lcl_mem[lcl_idx(cur_reg, r[3:0])]; // RL1 RL3
		else
			v = glb_reg[r[3:0]]; // RL1
		return v;
	endfunction

	// register waits on a load that does not land this cycle; flags and return passed in so callers re-evaluate
	function automatic logic src_hazard(input logic used, input logic [4:0] r, input logic [31:0] pend, input wrf_wr_t ld);
		return used && pend[r] && !(ld.valid && ld.dst == r); // RL9 RL14
	endfunction

	// frame pointer view of the last global
	wire [31:0] stack_frame_pointer_reg = glb_reg[WRF_FP_IDX]; // RL6

	// stall decoding
	wire busy = (state_reg != WRF_ST_IDLE);
	wire is_load = (i_issue.op == WRF_OP_LOAD);
	wire is_cond = (i_issue.op == WRF_OP_COND);
	wire is_frame = (i_issue.op == WRF_OP_CALL) || (i_issue.op == WRF_OP_RET);
	wire hz_a = src_hazard(i_issue.use_a, i_issue.src_a, pending, i_ld_ret); // RL9
	wire hz_b = src_hazard(i_issue.use_b, i_issue.src_b, pending, i_ld_ret); // RL9
	wire cond_live = cond_pending && !i_cond_done;
	wire hz_cc = i_issue.use_cc && cond_live; // RL11
	wire hz_cond = is_cond && cond_live; // RL11
	wire dst_busy = pending[i_issue.dst] && !(i_ld_ret.valid && i_ld_ret.dst == i_issue.dst);
	wire hz_load = is_load && ((sb_full && !i_ld_ret.valid) || dst_busy); // RL10
	wire hz_frame = is_frame && sb_any; // frames do not move under loads in flight
	wire stall = busy || hz_a || hz_b || hz_cc || hz_cond || hz_load || hz_frame;
	wire iss_go = i_issue.valid && !stall;
	wire call_go = iss_go && (i_issue.op == WRF_OP_CALL);
	wire ret_go = iss_go && (i_issue.op == WRF_OP_RET);
	wire uses_opnd = !is_frame;
	wire mem_done = i_mem_ack && (word_reg == WRF_WORD_LAST);
	wire fill_wr = (state_reg == WRF_ST_FILL) && i_mem_ack;

	assign o_issue_stall = i_issue.valid && stall; // RL9

	// pending flags and conditional tracking
	wrf_scoreboard #(
		.MAX_LOADS(MAX_LOADS)
	) u_sb (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_set(iss_go && is_load), // RL7
		.i_set_idx(i_issue.dst),
		.i_clr(i_ld_ret.valid), // RL8
		.i_clr_idx(i_ld_ret.dst),
		.i_cond_set(iss_go && is_cond), // RL11
		.i_cond_clr(i_cond_done),
		.o_pending(pending),
		.o_cond_pending(cond_pending),
		.o_full(sb_full),
		.o_any(sb_any)
	);

	// frame cache control and spill/fill sequencing
	always_comb
	begin
		cur_next = cur_reg;
		cnt_next = cnt_reg;
		depth_next = depth_reg;
		state_next = state_reg;
		word_next = word_reg;
		slot_next = slot_reg;
		req_next = req_reg;
		case (state_reg)
			WRF_ST_IDLE:
			begin
				if (call_go && cnt_reg == WRF_CNT_FULL)
				begin
					// cache full: oldest frame sits in the slot after the running one
					state_next = WRF_ST_SPILL; // RL5
					slot_next = cur_reg + WRF_SLOT_ONE;
					word_next = 4'h0;
					req_next.valid = 1'b1;
					req_next.write = 1'b1;
					req_next.addr = stack_frame_pointer_reg - WRF_SPILL_BACK; // RL6
					req_next.wdata = lcl_mem[lcl_idx(cur_reg + WRF_SLOT_ONE, 4'h0)];
				end
				else if (call_go)
				begin
					// free slot available, no memory traffic
					cur_next = cur_reg + WRF_SLOT_ONE; // RL3 RL4
					cnt_next = cnt_reg + WRF_CNT_ONE;
					depth_next = depth_reg + DEPTH_W'(1);
				end
				else if (ret_go && depth_reg > DEPTH_W'(1) && cnt_reg > WRF_CNT_ONE)
				begin
					// caller still cached
					cur_next = cur_reg - WRF_SLOT_ONE;
					cnt_next = cnt_reg - WRF_CNT_ONE;
					depth_next = depth_reg - DEPTH_W'(1);
				end
				else if (ret_go && depth_reg > DEPTH_W'(1))
				begin
					// caller was spilled: bring it back before it runs
					state_next = WRF_ST_FILL; // RL13
					slot_next = cur_reg - WRF_SLOT_ONE;
					word_next = 4'h0;
					req_next.valid = 1'b1;
					req_next.write = 1'b0;
					req_next.addr = stack_frame_pointer_reg - WRF_FRAME_BYTES; // RL6
					req_next.wdata = 32'h0000_0000;
				end
			end
			WRF_ST_SPILL:
			begin
				if (mem_done)
				begin
					// freed slot becomes the callee frame
					state_next = WRF_ST_IDLE;
					req_next = '0;
					cur_next = slot_reg; // RL5
					depth_next = depth_reg + DEPTH_W'(1);
				end
				else if (i_mem_ack)
				begin
					// next word of the oldest frame
					word_next = word_reg + WRF_WORD_ONE;
					req_next.addr = req_reg.addr + WRF_WORD_BYTES;
					req_next.wdata = lcl_mem[lcl_idx(slot_reg, word_reg + WRF_WORD_ONE)];
				end
			end
			WRF_ST_FILL:
			begin
				if (mem_done)
				begin
					// caller frame restored, resume there
					state_next = WRF_ST_IDLE;
					req_next = '0;
					cur_next = slot_reg; // RL13
					depth_next = depth_reg - DEPTH_W'(1);
				end
				else if (i_mem_ack)
				begin
					// next word of the caller frame
					word_next = word_reg + WRF_WORD_ONE;
					req_next.addr = req_reg.addr + WRF_WORD_BYTES;
				end
			end
			default:
			begin
				state_next = WRF_ST_IDLE;
				req_next = '0;
			end
		endcase
	end

	// frame state registers
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			cur_reg <= 2'h0;
			cnt_reg <= WRF_CNT_ONE;
			depth_reg <= DEPTH_W'(1);
			state_reg <= WRF_ST_IDLE;
			word_reg <= 4'h0;
			slot_reg <= 2'h0;
			req_reg <= '0;
		end
		else
		begin
			cur_reg <= cur_next;
			cnt_reg <= cnt_next;
			depth_reg <= depth_next;
			state_reg <= state_next;
			word_reg <= word_next;
			slot_reg <= slot_next;
			req_reg <= req_next;
		end
	end

	// global set: written in place, never touched by call or return
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			for (int i = 0; i < WRF_NUM_GLOBALS; i++)
				glb_reg[i] <= 32'h0000_0000;
		end
		else
		begin
			if (i_ld_ret.valid && !i_ld_ret.dst[4])
				glb_reg[i_ld_ret.dst[3:0]] <= i_ld_ret.data; // RL2 RL8
			if (i_alu_wr.valid && !i_alu_wr.dst[4])
				glb_reg[i_alu_wr.dst[3:0]] <= i_alu_wr.data; // RL2 RL12
		end
	end

	// local frame cache: fill words, load returns, alu results
	always_ff @(posedge i_ref_clk)
	begin
		if (fill_wr)
			lcl_mem[lcl_idx(slot_reg, word_reg)] <= i_mem_rdata; // RL13
		if (i_ld_ret.valid && i_ld_ret.dst[4])
			lcl_mem[lcl_idx(cur_reg, i_ld_ret.dst[3:0])] <= i_ld_ret.data; // RL8
		if (i_alu_wr.valid && i_alu_wr.dst[4])
			lcl_mem[lcl_idx(cur_reg, i_alu_wr.dst[3:0])] <= i_alu_wr.data; // RL12
	end

	// operand capture for accepted instructions
	always_comb
	begin
		opnd_next = '0;
		if (iss_go && uses_opnd)
		begin
			opnd_next.valid = 1'b1;
			opnd_next.a = fwd_read(i_issue.src_a); // RL14
			opnd_next.b = fwd_read(i_issue.src_b); // RL14
		end
	end

	// operand and bypass registers
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			opnd_reg <= '0;
			byp_reg <= '0;
		end
		else
		begin
			opnd_reg <= opnd_next;
			byp_reg <= i_alu_wr; // RL12
		end
	end

	assign o_opnd = opnd_reg;
	assign o_bypass = byp_reg;
	assign o_mem_req = req_reg;
	assign o_frame_busy = busy;
	assign o_call_depth = depth_reg;

endmodule

`default_nettype wire

// file: wrf_pkg.sv
// wrf_pkg: constants, opcodes and carrier structs for the windowed register file.
// assumes: one processor clock, synchronous active-high reset.
`default_nettype none

package wrf_pkg;

	// architectural shape
	localparam int WRF_NUM_GLOBALS = 16; // global set size
	localparam int WRF_NUM_LOCALS = 16; // local frame size
	localparam int WRF_DATA_W = 32; // register width
	localparam int WRF_CACHE_FRAMES = 4; // frames held on chip
	localparam int WRF_MAX_LOADS = 3; // outstanding loads
	localparam int WRF_DEPTH_W = 16; // call depth counter width

	// register name space: globals low, locals high
	localparam logic [4:0] first_global_reg = 5'h00;
	localparam logic [4:0] first_local_reg = 5'h10;
	localparam logic [4:0] last_local_reg = 5'h1F;
	localparam logic [3:0] WRF_FP_IDX = 4'hF; // last global holds the frame pointer

	// frame cache bookkeeping
	localparam logic [2:0] WRF_CNT_FULL = 3'h4; // cached frame count when full
	localparam logic [2:0] WRF_CNT_ONE = 3'h1; // only the running frame cached
	localparam logic [1:0] WRF_SLOT_ONE = 2'h1; // ring step
	localparam logic [3:0] WRF_WORD_LAST = 4'hF; // last word of a frame
	localparam logic [3:0] WRF_WORD_ONE = 4'h1;

	// memory stack layout, byte addresses
	localparam logic [31:0] WRF_WORD_BYTES = 32'h0000_0004;
	localparam logic [31:0] WRF_FRAME_BYTES = 32'h0000_0040; // 16 words
	localparam logic [31:0] WRF_SPILL_BACK = 32'h0000_00C0; // three frames below current

	// issue kinds
	typedef enum logic [2:0] {
		WRF_OP_ALU = 3'b000,
		WRF_OP_LOAD = 3'b001,
		WRF_OP_COND = 3'b010,
		WRF_OP_CALL = 3'b011,
		WRF_OP_RET = 3'b100
	} wrf_op_t;

	// frame spill/fill sequencer
	typedef enum logic [1:0] {
		WRF_ST_IDLE = 2'b00,
		WRF_ST_SPILL = 2'b01,
		WRF_ST_FILL = 2'b10
	} wrf_state_t;

	// instruction offered by the decoder
	typedef struct packed {
		logic valid;
		wrf_op_t op;
		logic use_a;
		logic use_b;
		logic use_cc;
		logic [4:0] src_a;
		logic [4:0] src_b;
		logic [4:0] dst;
	} wrf_issue_t;

	// register write: alu result, load return, bypass
	typedef struct packed {
		logic valid;
		logic [4:0] dst;
		logic [31:0] data;
	} wrf_wr_t;

	// operands handed to the execution units
	typedef struct packed {
		logic valid;
		logic [31:0] a;
		logic [31:0] b;
	} wrf_opnd_t;

	// frame traffic toward the memory bus
	typedef struct packed {
		logic valid;
		logic write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} wrf_mem_req_t;

endpackage

`default_nettype wire

// file: wrf_scoreboard.sv
// wrf_scoreboard: pending flags for load targets and the condition code.
// assumes: the caller never sets a flag that is already pending.
`default_nettype none

module wrf_scoreboard
	import wrf_pkg::*;
#(
	parameter int MAX_LOADS = WRF_MAX_LOADS
)
(
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_set,
	input wire logic [4:0] i_set_idx,
	input wire logic i_clr,
	input wire logic [4:0] i_clr_idx,
	input wire logic i_cond_set,
	input wire logic i_cond_clr,
	output logic [31:0] o_pending,
	output logic o_cond_pending,
	output logic o_full,
	output logic o_any
);

	localparam int CW = $clog2(MAX_LOADS + 1);

	logic [31:0] pend_reg; // one flag per visible register
	logic [31:0] pend_next;
	logic [CW-1:0] cnt_reg; // loads in flight
	logic [CW-1:0] cnt_next;
	logic cond_reg; // conditional instruction pending
	logic cond_next;
	wire [31:0] set_mask = i_set ? (32'h0000_0001 << i_set_idx) : 32'h0000_0000;
	wire [31:0] clr_mask = i_clr ? (32'h0000_0001 << i_clr_idx) : 32'h0000_0000;
	wire clr_eff = |(clr_mask & pend_reg); // only a real pending flag counts down

	// set beats clear on the same register
	assign pend_next = (pend_reg & ~clr_mask) | set_mask; // RL7 RL8
	assign cnt_next = CW'(cnt_reg + CW'(i_set) - CW'(clr_eff)); // RL10
	assign cond_next = i_cond_set | (cond_reg & ~i_cond_clr); // RL11

	// flag state
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			pend_reg <= 32'h0000_0000;
			cnt_reg <= '0;
			cond_reg <= 1'b0;
		end
		else
		begin
			pend_reg <= pend_next;
			cnt_reg <= cnt_next;
			cond_reg <= cond_next;
		end
	end

	assign o_pending = pend_reg;
	assign o_cond_pending = cond_reg;
	assign o_full = (cnt_reg >= CW'(MAX_LOADS)); // RL10
	assign o_any = (cnt_reg != '0);

endmodule

`default_nettype wire

// file: wrf_top_monitor.sv
// wrf_top_monitor: port-level assertions for the windowed register file.
// assumes: bound to wrf_top, one clock, synchronous active-high reset.
`default_nettype none

module wrf_top_monitor
	import wrf_pkg::*;
#(
	parameter int DEPTH_W = WRF_DEPTH_W
)
(
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire wrf_issue_t i_issue,
	input wire wrf_wr_t i_alu_wr,
	input wire wrf_wr_t i_ld_ret,
	input wire logic i_cond_done,
	input wire logic i_mem_ack,
	input wire logic [31:0] i_mem_rdata,
	input wire logic o_issue_stall,
	input wire wrf_opnd_t o_opnd,
	input wire wrf_wr_t o_bypass,
	input wire wrf_mem_req_t o_mem_req,
	input wire logic o_frame_busy,
	input wire logic [DEPTH_W-1:0] o_call_depth
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);

	wire take = i_issue.valid && !o_issue_stall; // instruction accepted
	wire opnd_op = i_issue.op inside {WRF_OP_ALU, WRF_OP_LOAD, WRF_OP_COND}; // kinds that read operands
	wire take_ld = take && i_issue.op == WRF_OP_LOAD; // load accepted
	logic [2:0] ld_cnt_reg; // loads in flight
	logic [2:0] ld_cnt_next;

	assign ld_cnt_next = ld_cnt_reg + 3'(take_ld) - 3'(i_ld_ret.valid);

	// count loads in flight
	always_ff @(posedge i_ref_clk)
		ld_cnt_reg <= i_srst ? 3'h0 : ld_cnt_next;

	property p_opnd;
		1 |=> o_opnd.valid == $past(take && opnd_op);
	endproperty
	a_opnd: assert property (p_opnd) else $error("operand valid does not follow issue");
	property p_bypass;
		i_alu_wr.valid |=> o_bypass == $past(i_alu_wr);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass copy wrong");
	property p_busy;
		o_frame_busy |-> !take;
	endproperty
	a_busy: assert property (p_busy) else $error("issue taken during frame move");
	property p_hold;
		o_mem_req.valid && !i_mem_ack |=> $stable(o_mem_req);
	endproperty
	a_hold: assert property (p_hold) else $error("memory request changed before ack");
	property p_step;
		o_mem_req.valid && i_mem_ack ##1 o_mem_req.valid |-> o_mem_req.addr == $past(o_mem_req.addr) + 32'h4;
	endproperty
	a_step: assert property (p_step) else $error("frame word address not stepped by four");
	property p_call;
		take && i_issue.op == WRF_OP_CALL ##1 !o_frame_busy |-> o_call_depth == $past(o_call_depth) + DEPTH_W'(1);
	endproperty
	a_call: assert property (p_call) else $error("call depth not incremented");
	property p_bound;
		$rose(o_frame_busy) |-> ##[1:200] !o_frame_busy;
	endproperty
	a_bound: assert property (p_bound) else $error("frame move does not end");
	property p_ld_max;
		take_ld |-> ld_cnt_reg < 3'h3 || i_ld_ret.valid;
	endproperty
	a_ld_max: assert property (p_ld_max) else $error("fourth load accepted");
	property p_ld_flag;
		take_ld ##1 (i_issue.valid && i_issue.use_a && i_issue.src_a == $past(i_issue.dst)
			&& !(i_ld_ret.valid && i_ld_ret.dst == $past(i_issue.dst))) |-> o_issue_stall;
	endproperty
	a_ld_flag: assert property (p_ld_flag) else $error("reader of loading register not stalled");

	c_spill: cover property (o_mem_req.valid && o_mem_req.write && i_mem_ack);
	c_fill: cover property (o_mem_req.valid && !o_mem_req.write && i_mem_ack);
	c_fwd: cover property ($fell(o_issue_stall) && i_ld_ret.valid);
endmodule

`default_nettype wire

// file: wrf_mem_model.sv
// wrf_mem_model: memory stack behind the frame spill/fill port.
// assumes: request held until acknowledged, one word per ack pulse.
`default_nettype none

module wrf_mem_model
	import wrf_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire wrf_mem_req_t i_req,
	input wire logic i_slow,
	output logic o_ack,
	output logic [31:0] o_rdata
);
	logic [31:0] mem [0:255]; // stack image, word addressed
	logic wait_reg = 1'h0; // slow mode idles one cycle per word
	logic [31:0] noise_reg = 32'h0; // junk on the data lines outside a read ack

	// ack each held word, promptly or slowly; store written words
	always @(posedge i_ref_clk)
	begin
		noise_reg <= noise_reg + 32'h1357_9BDF;
		o_ack <= 1'h0;
		if (i_srst)
			wait_reg <= 1'h0;
		else if (o_ack && i_req.write)
			mem[i_req.addr[9:2]] <= i_req.wdata;
		else if (i_req.valid && !o_ack)
		begin
			wait_reg <= i_slow && !wait_reg;
			o_ack <= !(i_slow && !wait_reg);
		end
	end

	assign o_rdata = (o_ack && !i_req.write) ? mem[i_req.addr[9:2]] : noise_reg;
endmodule

`default_nettype wire

// file: wrf_top_bench.sv
// wrf_top_bench: self-checking bench for wrf_top with a memory stack model.
// assumes: wrf_pkg, wrf_top, wrf_top_monitor and wrf_mem_model compiled first.
`default_nettype none

module wrf_top_bench
	import wrf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [31:0] BASE = 32'h0000_1000; // frame k sits at BASE + 64*(k-1)
	logic i_ref_clk = 1'h0;
	logic i_srst = 1'h1;
	wrf_issue_t i_issue = '0;
	wrf_wr_t i_alu_wr = '0;
	wrf_wr_t i_ld_ret = '0;
	logic i_cond_done = 1'h0;
	logic slow = 1'h0; // when set, memory answers every third cycle
	logic i_mem_ack;
	logic [31:0] i_mem_rdata;
	logic o_issue_stall;
	wrf_opnd_t o_opnd;
	wrf_wr_t o_bypass;
	wrf_mem_req_t o_mem_req;
	logic o_frame_busy;
	logic [15:0] o_call_depth;
	int miscompares = 0;
	int tests_run = 0;
	int stalls;
	logic [31:0] op_a; // operand a of the last issue
	typedef struct packed {logic [4:0] d; logic [31:0] v;} wrf_row_t;
	wrf_row_t rows [4] = '{'{5'h00, 32'h1111_0000}, '{5'h0E, 32'h2222_000E},
		'{5'h10, 32'h3333_0010}, '{5'h1F, 32'h4444_001F}};

	wrf_top i_dut (.i_ref_clk, .i_srst, .i_issue, .i_alu_wr, .i_ld_ret, .i_cond_done, .i_mem_ack,
		.i_mem_rdata, .o_issue_stall, .o_opnd, .o_bypass, .o_mem_req, .o_frame_busy, .o_call_depth);
	wrf_mem_model i_mem (.i_ref_clk, .i_srst, .i_req(o_mem_req), .i_slow(slow), .o_ack(i_mem_ack),
		.o_rdata(i_mem_rdata));

	initial
		forever #20 i_ref_clk = ~i_ref_clk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	function automatic wrf_issue_t mk(input wrf_op_t op, input logic [4:0] a, input logic [4:0] d, input logic cc);
		return '{1'h1, op, 1'h1, 1'h0, cc, a, 5'h00, d};
	endfunction

	// offer one instruction, wait out stalls, capture its operand
	task automatic iss(input wrf_op_t op, input logic [4:0] a, input logic [4:0] d, input logic cc);
		@(negedge i_ref_clk);
		i_issue = mk(op, a, d, cc);
		stalls = 0;
		#1;
		while (o_issue_stall && stalls < 300)
		begin
			@(negedge i_ref_clk);
			#1;
			stalls++;
		end
		chk(32'(o_issue_stall), 32'h0);
		@(negedge i_ref_clk);
		op_a = o_opnd.a;
		i_issue = '0;
	endtask

	task automatic rd(input logic [4:0] a);
		iss(WRF_OP_ALU, a, 5'h00, 1'h0);
	endtask

	task automatic wr(input logic [4:0] d, input logic [31:0] v);
		@(negedge i_ref_clk);
		i_alu_wr = '{1'h1, d, v};
		@(negedge i_ref_clk);
		i_alu_wr = '0;
		chk(o_bypass.data, v);
	endtask

	task automatic wbusy;
		for (int n = 0; n < 200 && o_frame_busy; n++)
			@(negedge i_ref_clk);
		chk(32'(o_frame_busy), 32'h0);
	endtask

	initial
	begin
		#400000;
		miscompares++;
		final_report();
	end

	initial
	begin
		repeat (8) @(negedge i_ref_clk);
		i_srst = 1'h0;
		chk(32'(o_call_depth), 32'h1);
		chk(32'(o_mem_req.valid), 32'h0);
		$display("test reset done");
		// write then read back globals and locals
		foreach (rows[i])
		begin
			wr(rows[i].d, rows[i].v);
			rd(rows[i].d);
			chk(op_a, rows[i].v);
		end
		$display("test table done");
		// three loads in flight, a fourth waits
		@(negedge i_ref_clk);
		for (int k = 4; k < 7; k++)
		begin
			i_issue = mk(WRF_OP_LOAD, 5'h00, 5'(k), 1'h0);
			#1 chk(32'(o_issue_stall), 32'h0);
			@(negedge i_ref_clk);
		end
		i_issue = mk(WRF_OP_LOAD, 5'h00, 5'h07, 1'h0);
		#1 chk(32'(o_issue_stall), 32'h1);
		@(negedge i_ref_clk);
		i_ld_ret = '{1'h1, 5'h05, 32'hD000_0005};
		#1 chk(32'(o_issue_stall), 32'h0);
		@(negedge i_ref_clk);
		i_ld_ret = '0;
		i_issue = mk(WRF_OP_ALU, 5'h07, 5'h00, 1'h0);
		#1 chk(32'(o_issue_stall), 32'h1);
		@(negedge i_ref_clk);
		i_ld_ret = '{1'h1, 5'h07, 32'hD000_0007};
		#1 chk(32'(o_issue_stall), 32'h0);
		@(negedge i_ref_clk);
		i_ld_ret = '0;
		i_issue = '0;
		chk(o_opnd.a, 32'hD000_0007);
		chk(o_opnd.b, 32'h1111_0000);
		rd(5'h00);
		chk(32'(stalls), 32'h0);
		@(negedge i_ref_clk);
		i_ld_ret = '{1'h1, 5'h04, 32'hD000_0004};
		@(negedge i_ref_clk);
		i_ld_ret = '{1'h1, 5'h06, 32'hD000_0006};
		@(negedge i_ref_clk);
		i_ld_ret = '0;
		rd(5'h04);
		chk(op_a, 32'hD000_0004);
		$display("test loads done");
		// pending condition stalls only its users
		iss(WRF_OP_COND, 5'h00, 5'h00, 1'h0);
		rd(5'h00);
		chk(32'(stalls), 32'h0);
		@(negedge i_ref_clk);
		i_issue = mk(WRF_OP_ALU, 5'h00, 5'h00, 1'h1);
		#1 chk(32'(o_issue_stall), 32'h1);
		@(negedge i_ref_clk);
		i_cond_done = 1'h1;
		#1 chk(32'(o_issue_stall), 32'h0);
		@(negedge i_ref_clk);
		i_cond_done = 1'h0;
		i_issue = '0;
		$display("test cond done");
		// four nested calls: the last spills frame one to the stack
		wr(5'h0E, 32'h0000_0E0E);
		for (int k = 1; k < 5; k++)
		begin
			wr(5'h10, 32'hF000_0000 + k);
			wr(5'h0F, BASE + 32'h40 * (k - 1));
			iss(WRF_OP_CALL, 5'h00, 5'h00, 1'h0);
			chk(32'(o_frame_busy), 32'(k == 4));
			if (k == 4)
			begin
				// an instruction offered during the spill must wait
				@(negedge i_ref_clk);
				i_issue = mk(WRF_OP_ALU, 5'h00, 5'h00, 1'h0);
				#1 chk(32'(o_issue_stall), 32'h1);
				@(negedge i_ref_clk);
				i_issue = '0;
			end
			wbusy();
			chk(32'(o_call_depth), k + 1);
		end
		chk(i_mem.mem[0], 32'hF000_0001);
		chk(i_mem.mem[15], 32'h4444_001F);
		// returns: three cached, the last refilled from memory slowly
		wr(5'h10, 32'hF000_0005);
		for (int k = 5; k > 1; k--)
		begin
			wr(5'h0F, BASE + 32'h40 * (k - 1));
			slow = (k == 2);
			iss(WRF_OP_RET, 5'h00, 5'h00, 1'h0);
			wbusy();
			chk(32'(o_call_depth), k - 1);
			rd(5'h10);
			chk(op_a, 32'hF000_0000 + k - 1);
		end
		rd(5'h0E);
		chk(op_a, 32'h0000_0E0E);
		$display("test frames done");
		// reset in mid-run brings the depth back to one
		iss(WRF_OP_CALL, 5'h00, 5'h00, 1'h0);
		i_srst = 1'h1;
		@(negedge i_ref_clk);
		i_srst = 1'h0;
		chk(32'(o_call_depth), 32'h1);
		$display("test rereset done");
		final_report();
	end
endmodule

bind wrf_top wrf_top_monitor #(.DEPTH_W(DEPTH_W)) u_mon (.i_ref_clk, .i_srst, .i_issue, .i_alu_wr, .i_ld_ret,
	.i_cond_done, .i_mem_ack, .i_mem_rdata, .o_issue_stall, .o_opnd, .o_bypass, .o_mem_req, .o_frame_busy,
	.o_call_depth);

`default_nettype wire
